// >>> design/pms_pin_share.sv
// programming-mode pin sharing: selects scan port or normal pins
// assumes the shared pins are asynchronous to clk_i and tck_i is the link clock
`timescale 1ns/100ps
`include "pms_map.svh"
module pms_pin_share #(
    parameter int SHIFT_WIDTH = 8
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // programming enable, active low
    input  wire logic prog_en_n_i,
    // shared serial pins
    input  wire logic tdi_in0_i,
    input  wire logic tms_i,
    input  wire logic tdo_in1_i,
    output logic      tdo_in1_o,
    output logic      tdo_in1_oe_n_o,
    input  wire logic tck_clk2_i,
    // dedicated clock pins
    input  wire logic global_clock_0_i,
    input  wire logic rst_clk1_n_i,
    // logic array side
    output logic      ded_in0_o,
    output logic      ded_in1_o,
    output logic      glb_clk0_o,
    output logic      global_clock_1_o,
    output logic      global_clock_2_o,
    output logic      array_rst_n_o,
    output logic      prog_mode_o,
    output logic      isp_tms_o,
    output logic      isp_tdi_o,
    output logic [SHIFT_WIDTH-1:0] shift_data_o
);
    pms_pkg::pms_mode_t mode_r;
    logic en_n_s;
    logic in0_s;
    logic in1_s;
    logic tms_s;
    logic tdi_s;
    logic rst1_n_s;
    logic tdo_w;
    logic tms_seen_w;
    logic shift_rst_w;
    logic [SHIFT_WIDTH-1:0] data_w;
    logic [SHIFT_WIDTH-1:0] hold_w;
    logic tgl_w;
    logic tgl_s;
    logic tgl_prev_r;

    pms_sync #(.RST_VAL(1'b1)) u_sync_en (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(prog_en_n_i), .q_o(en_n_s));
    pms_sync #(.RST_VAL(1'b0)) u_sync_in0 (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(tdi_in0_i), .q_o(in0_s));
    pms_sync #(.RST_VAL(1'b0)) u_sync_in1 (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(tdo_in1_i), .q_o(in1_s));
    pms_sync #(.RST_VAL(1'b0)) u_sync_tms (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(tms_seen_w), .q_o(tms_s));
    pms_sync #(.RST_VAL(1'b0)) u_sync_tdi (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(data_w[SHIFT_WIDTH-1]),
                                           .q_o(tdi_s));
    pms_sync #(.RST_VAL(1'b0)) u_sync_rst (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(rst_clk1_n_i), .q_o(rst1_n_s));
    pms_sync #(.RST_VAL(1'b0)) u_sync_frm (.clk_i(clk_i), .rst_i(sys_rst_i), .d_i(tgl_w), .q_o(tgl_s));

    // mode follows the synchronised enable pin
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode_r <= pms_pkg::PMS_NORMAL;
        end else if (en_n_s == `PMS_PROG_ACTIVE) begin
            mode_r <= pms_pkg::PMS_PROG;
        end else begin
            mode_r <= pms_pkg::PMS_NORMAL;
        end
    end

    // shift logic held in reset outside programming mode, except the held word and frame toggle (reset by sys_rst_i only)
    assign shift_rst_w = sys_rst_i | prog_en_n_i;

    pms_shift #(.WIDTH(SHIFT_WIDTH)) u_shift (
        .tck_i      (tck_clk2_i),
        .rst_i      (shift_rst_w),
        .hold_rst_i (sys_rst_i),
        .shift_en_i (1'b1),
        .tdi_i      (tdi_in0_i),
        .tms_i      (tms_i),
        .tdo_o      (tdo_w),
        .data_o     (data_w),
        .tms_seen_o (tms_seen_w),
        .hold_o     (hold_w),
        .frame_tgl_o(tgl_w)
    );

    // word crosses by a per-frame toggle; the held word is stable while it is taken
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tgl_prev_r   <= `PMS_SHIFT_RST;
            shift_data_o <= '0;
        end else begin
            tgl_prev_r <= tgl_s;
            if (tgl_s != tgl_prev_r) begin
                shift_data_o <= hold_w;
            end
        end
    end

    // data-out pin driven only in programming mode
    always_comb begin
        tdo_in1_o      = tdo_w;
        tdo_in1_oe_n_o = prog_en_n_i;
    end

    // outputs toward the array
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ded_in0_o    <= `PMS_IDLE_LEVEL;
            ded_in1_o    <= `PMS_IDLE_LEVEL;
            isp_tms_o    <= `PMS_IDLE_LEVEL;
            isp_tdi_o    <= `PMS_IDLE_LEVEL;
            prog_mode_o  <= 1'b0;
        end else begin
            case (mode_r)
                pms_pkg::PMS_PROG: begin
                    ded_in0_o    <= `PMS_IDLE_LEVEL;
                    ded_in1_o    <= `PMS_IDLE_LEVEL;
                    isp_tms_o    <= tms_s;
                    isp_tdi_o    <= tdi_s;
                    prog_mode_o  <= 1'b1;
                end
                pms_pkg::PMS_NORMAL: begin
                    ded_in0_o    <= in0_s;
                    ded_in1_o    <= in1_s;
                    isp_tms_o    <= `PMS_IDLE_LEVEL;
                    isp_tdi_o    <= `PMS_IDLE_LEVEL;
                    prog_mode_o  <= 1'b0;
                end
                default: begin
                    ded_in0_o    <= `PMS_IDLE_LEVEL;
                    ded_in1_o    <= `PMS_IDLE_LEVEL;
                    isp_tms_o    <= `PMS_IDLE_LEVEL;
                    isp_tdi_o    <= `PMS_IDLE_LEVEL;
                    prog_mode_o  <= 1'b0;
                end
            endcase
        end
    end

    // global reset from the synchronised reset/clock-1 pin
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            array_rst_n_o <= 1'b0;
        end else begin
            array_rst_n_o <= rst1_n_s;
        end
    end

    // clock distribution; clock 2 gated low by the enable pin itself
    always_comb begin
        glb_clk0_o       = global_clock_0_i;
        global_clock_1_o = rst_clk1_n_i;
        global_clock_2_o = tck_clk2_i & prog_en_n_i;
    end
endmodule // pms_pin_share

// >>> shared/pms_map.svh
// constants for the programming-mode pin sharing block
// assumes inclusion by bare name from design files
`ifndef PMS_MAP_SVH
`define PMS_MAP_SVH
`define PMS_SYNC_STAGES    2
`define PMS_PROG_ACTIVE    1'b0
`define PMS_IDLE_LEVEL     1'b0
`define PMS_SHIFT_RST      1'b0
`endif

// >>> shared/pms_pkg.sv
// types for the programming-mode pin sharing block
// assumes nothing beyond a SystemVerilog compiler
package pms_pkg;
    typedef enum logic [1:0] {
        PMS_NORMAL = 2'b00,
        PMS_PROG   = 2'b01
    } pms_mode_t;
endpackage

// >>> design/pms_sync.sv
// two-stage level synchroniser
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
module pms_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule // pms_sync

// >>> design/pms_shift.sv
// serial shift register clocked by the link clock
// assumes rst_i is held whenever tck_i runs outside programming mode
`timescale 1ns/100ps
`include "pms_map.svh"
module pms_shift #(
    parameter int WIDTH = 8
) (
    // link clock and reset
    input  wire logic             tck_i,
    input  wire logic             rst_i,
    input  wire logic             hold_rst_i,
    // serial port
    input  wire logic             shift_en_i,
    input  wire logic             tdi_i,
    input  wire logic             tms_i,
    output logic                  tdo_o,
    // captured contents and mode-select sample
    output logic [WIDTH-1:0]      data_o,
    output logic                  tms_seen_o,
    // word of the last complete frame and a toggle per frame
    output logic [WIDTH-1:0]      hold_o,
    output logic                  frame_tgl_o
);
    localparam int CNT_W = (WIDTH > 1) ? $clog2(WIDTH) : 1;
    logic [WIDTH-1:0] sr_r;
    logic [CNT_W-1:0] cnt_r;
    logic             last_w;
    assign last_w = (cnt_r == CNT_W'(WIDTH - 1));
    // bit position within the frame
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_r <= '0;
        end else if (shift_en_i) begin
            cnt_r <= last_w ? '0 : CNT_W'(cnt_r + 1'b1);
        end
    end
    // held word stands a whole frame, long enough for the system clock to take it
    always_ff @(posedge tck_i or posedge hold_rst_i) begin
        if (hold_rst_i) begin
            hold_o      <= '0;
            frame_tgl_o <= `PMS_SHIFT_RST;
        end else if (shift_en_i && last_w) begin
            hold_o      <= {tdi_i, sr_r[WIDTH-1:1]};
            frame_tgl_o <= ~frame_tgl_o;
        end
    end
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            sr_r <= '0;
        end else if (shift_en_i) begin
            sr_r <= {tdi_i, sr_r[WIDTH-1:1]};
        end
    end
    always_ff @(posedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            tms_seen_o <= `PMS_SHIFT_RST;
        end else begin
            tms_seen_o <= tms_i;
        end
    end
    // data out changes on the falling edge, as usual for a scan port
    always_ff @(negedge tck_i or posedge rst_i) begin
        if (rst_i) begin
            tdo_o <= `PMS_SHIFT_RST;
        end else begin
            tdo_o <= sr_r[0];
        end
    end
    assign data_o = sr_r;
endmodule // pms_shift

// >>> tb/pms_pin_share_asserts.sv
// checker on the pin sharing block ports
// assumes a bind into pms_pin_share
`timescale 1ns/100ps
module pms_pin_share_asserts #(parameter int SHIFT_WIDTH = 8) (
    input wire logic clk_i, sys_rst_i, prog_en_n_i, tdi_in0_i, tms_i, tdo_in1_i, tck_clk2_i,
    input wire logic global_clock_0_i, rst_clk1_n_i, tdo_in1_oe_n_o, ded_in0_o, ded_in1_o,
    input wire logic glb_clk0_o, global_clock_1_o, global_clock_2_o, array_rst_n_o, prog_mode_o,
    input wire logic isp_tms_o,
    input wire logic [SHIFT_WIDTH-1:0] shift_data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    property p_oe; tdo_in1_oe_n_o == prog_en_n_i; endproperty
    property p_clk; glb_clk0_o == global_clock_0_i && global_clock_1_o == rst_clk1_n_i; endproperty
    property p_clk2; global_clock_2_o == (tck_clk2_i & prog_en_n_i); endproperty
    property p_mode; (!prog_en_n_i)[*5] |-> prog_mode_o && !ded_in0_o && !ded_in1_o; endproperty
    property p_norm;
        (prog_en_n_i && $stable(tdi_in0_i) && $stable(tdo_in1_i))[*6]
            |-> !prog_mode_o && ded_in0_o == tdi_in0_i && ded_in1_o == tdo_in1_i;
    endproperty
    property p_rst; $stable(rst_clk1_n_i)[*5] |-> array_rst_n_o == rst_clk1_n_i; endproperty
    property p_tms; (!prog_en_n_i && $stable(tms_i))[*8] |-> isp_tms_o == tms_i; endproperty
    property p_hold; prog_en_n_i[*8] |=> $stable(shift_data_o); endproperty
    a_oe: assert property (p_oe) else $error("oe");
    a_clk: assert property (p_clk) else $error("clk");
    a_clk2: assert property (p_clk2) else $error("clk2");
    a_mode: assert property (p_mode) else $error("mode");
    a_norm: assert property (p_norm) else $error("norm");
    a_rst: assert property (p_rst) else $error("rst");
    a_tms: assert property (p_tms) else $error("tms");
    a_hold: assert property (p_hold) else $error("hold");
    c_prog: cover property ($rose(prog_mode_o));
    c_arst: cover property ($fell(array_rst_n_o));
    c_shift: cover property (!tdo_in1_oe_n_o && tck_clk2_i);
endmodule // pms_pin_share_asserts
bind pms_pin_share pms_pin_share_asserts #(.SHIFT_WIDTH(SHIFT_WIDTH)) chk_u (.*);

// >>> tb/pms_isp_model.sv
// programming controller on the serial pins
// assumes sampling on tck rise and output update on tck fall
`timescale 1ns/100ps
module pms_isp_model (
    input  wire logic tdo_i,
    output logic      tms_o,
    output logic      tdi_o,
    output logic      tck_o
);
    // link clock stands still outside frames
    initial begin
        tms_o = 1'b0;
        tdi_o = 1'b0;
        tck_o = 1'b0;
    end
    task automatic frame(input logic [7:0] din, input logic tms, output logic [7:0] dout);
        tms_o = tms;
        for (int i = 0; i < 8; i++) begin
            tdi_o = din[i];
            #16 dout[i] = tdo_i;
            tck_o = 1'b1;
            #16 tck_o = 1'b0;
        end
    endtask
endmodule // pms_isp_model

// >>> tb/pms_pin_share_tb.sv
// self-checking bench for the pin sharing block
// assumes the model drives the serial pins in programming mode
`timescale 1ns/100ps
module pms_pin_share_tb;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, prog_en_n_i = 1'b1, in0_r = 1'b0, in1_r = 1'b0;
    logic global_clock_0_i = 1'b0, rst_clk1_n_i = 1'b1;
    logic m_tdi, m_tms, tck, tdo_o, oe_n, d0, d1, c0, c1, c2, arst_n, mode, itms, itdi;
    int c2_rises = 0;
    always @(posedge c2) c2_rises++;
    logic [7:0] sdata, dout;
    wire tdo_pin = oe_n ? in1_r : tdo_o;
    int error_cnt = 0;
    int checked = 0;
    always #20 clk_i = ~clk_i;
    pms_isp_model isp_u (.tdo_i(tdo_pin), .tms_o(m_tms), .tdi_o(m_tdi), .tck_o(tck));
    pms_pin_share #(.SHIFT_WIDTH(8)) dut_u (.clk_i, .sys_rst_i, .prog_en_n_i,
        .tdi_in0_i(prog_en_n_i ? in0_r : m_tdi), .tms_i(m_tms), .tdo_in1_i(tdo_pin), .tdo_in1_o(tdo_o),
        .tdo_in1_oe_n_o(oe_n), .tck_clk2_i(tck), .global_clock_0_i, .rst_clk1_n_i, .ded_in0_o(d0),
        .ded_in1_o(d1), .glb_clk0_o(c0), .global_clock_1_o(c1), .global_clock_2_o(c2),
        .array_rst_n_o(arst_n), .prog_mode_o(mode), .isp_tms_o(itms), .isp_tdi_o(itdi), .shift_data_o(sdata));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic t_normal;
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_i) {in0_r, in1_r} <= 2'(v);
            cyc(6);
            chk("normal", {4'h0, mode, oe_n, d0, d1}, {6'h01, 2'(v)});
        end
    endtask
    task automatic t_clocks;
        for (int v = 0; v < 4; v++) begin
            @(posedge clk_i) {global_clock_0_i, rst_clk1_n_i} <= 2'(v);
            cyc(4);
            chk("clocks", {5'h0, c0, c1, arst_n}, {5'h0, 2'(v), v[0]});
        end
    endtask
    task automatic t_prog;
        @(posedge clk_i) prog_en_n_i <= 1'b0;
        cyc(5);
        chk("enter", {4'h0, mode, oe_n, d0, d1}, 8'h08);
        isp_u.frame(8'ha5, 1'b1, dout);
        cyc(8);
        chk("load", sdata, 8'ha5);
        chk("ctl", {6'h0, itms, itdi}, 8'h03);
        isp_u.frame(8'h3c, 1'b0, dout);
        chk("tdo", dout, 8'ha5);
        cyc(8);
        chk("ctl", {6'h0, itms, itdi}, 8'h00);
        chk("clk2_gated", 8'(c2_rises), 8'h00);
        @(posedge clk_i) prog_en_n_i <= 1'b1;
        cyc(6);
        chk("leave", {4'h0, mode, oe_n, d0, d1}, 8'h07);
        isp_u.frame(8'hff, 1'b1, dout);
        cyc(8);
        chk("hold", sdata, 8'h3c);
        chk("clk2", 8'(c2_rises), 8'h08);
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_normal;
        t_clocks;
        t_prog;
        print_verdict;
    end
    initial begin
        #200us;
        error_cnt++;
        print_verdict;
    end
endmodule // pms_pin_share_tb
